// ### core/act_cmd_device.sv
/*
  Actuator end of the command port: source address from default plus
  select pins, address claim with arbitrary retry, commanded address,
  control-frame decode, manual override, overload trip and timeout.
  Assumes the link delivers whole frames and that pins are asynchronous.
*/
`timescale 1ns/1ns
module act_cmd_device
  import act_cmd_pkg::*;
#(
  parameter int unsigned OVERLOAD_CYC = OVERLOAD_MS * CLK_KHZ,
  parameter int unsigned TIMEOUT_CYC  = TIMEOUT_MS * CLK_KHZ,
  parameter int unsigned FEEDBACK_CYC = FEEDBACK_MS * CLK_KHZ,
  parameter int unsigned CLAIM_CYC    = CLAIM_WAIT_MS * CLK_KHZ
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // link
  act_cmd_if.device        link,
  // pins
  input  wire logic        addr_select_bit_one_i,
  input  wire logic        addr_select_bit_two_i,
  input  wire logic        addr_select_bit_three_i,
  input  wire logic        manual_extend_i,
  input  wire logic        manual_retract_i,
  // motor side
  input  wire logic        motor_starting_i,
  input  wire logic [15:0] motor_current_i,
  input  wire logic [15:0] fb_position_i,
  input  wire logic [15:0] fb_current_i,
  input  wire logic [7:0]  fb_speed_i,
  input  wire logic [7:0]  fb_motion_i,
  input  wire logic [7:0]  fb_error_i,
  // commands to motion control, status and address
  output logic [15:0]      target_position_o,
  output logic [15:0]      current_limit_o,
  output logic [7:0]       target_speed_o,
  output logic [5:0]       control_bits_o,
  output logic             motion_run_o,
  output logic             drive_extend_o,
  output logic             drive_retract_o,
  output logic             overload_o,
  output logic             msg_timeout_o,
  output logic             brake_o,
  output logic [7:0]       source_addr_o,
  output logic             addr_claimed_o
);
  import act_cmd_pkg::*;

  typedef enum logic [1:0] {
    CL_START = 2'b00,
    CL_WAIT  = 2'b01,
    CL_DONE  = 2'b10,
    CL_FAIL  = 2'b11
  } claim_st_t;

  typedef struct packed {
    logic [1:0]  sel1_s, sel2_s, sel3_s, ext_s, ret_s;
    logic        sel_loaded;
    logic [1:0]  sel_wait;
    logic [7:0]  sa;
    claim_st_t   cst;
    logic [31:0] claim_cnt;
    logic [15:0] pos;
    logic [15:0] cur;
    logic [7:0]  spd;
    logic [5:0]  ctl;
    logic        run;
    logic        ovl;
    logic [31:0] ovl_cnt;
    logic [31:0] to_cnt;
    logic        tout;
    logic [31:0] fb_cnt;
    logic        ext, ret, brake;
    can_frame_t  tx;
    logic        tx_v;
    logic        claimed;
  } dev_st_t;

  localparam dev_st_t RESET_ST = '{cst: CL_START, sa: DEFAULT_SA,
                                   default: '0};
  // edges before a synchronised strap is valid
  localparam logic [1:0] SYNC_FILL = 2'h2;
  localparam logic [7:0] PDU2_MIN  = 8'hf0;

  dev_st_t st_r, st_nxt;
  logic    manual;
  logic [7:0] da, rsa;
  logic [17:0] pgn;
  logic    en_new;
  logic [63:0] name;

  always_comb begin
    name    = build_name();
    manual  = st_r.ext_s[1] | st_r.ret_s[1];
    // group-extension groups keep their low byte in the id
    pgn     = (link.h2d_frame.id[23:16] >= PDU2_MIN) ?
              link.h2d_frame.id[25:8] : {link.h2d_frame.id[25:16], 8'h00};
    da      = link.h2d_frame.id[15:8];
    rsa     = link.h2d_frame.id[7:0];
    en_new  = 1'b0;
    st_nxt  = st_r;
    st_nxt.tx_v = 1'b0;
    st_nxt.sel1_s = {st_r.sel1_s[0], addr_select_bit_one_i};
    st_nxt.sel2_s = {st_r.sel2_s[0], addr_select_bit_two_i};
    st_nxt.sel3_s = {st_r.sel3_s[0], addr_select_bit_three_i};
    st_nxt.ext_s  = {st_r.ext_s[0], manual_extend_i};
    st_nxt.ret_s  = {st_r.ret_s[0], manual_retract_i};

    // strap taken once synchronisers have filled; open pins read zero
    if (!st_r.sel_loaded) begin
      if (st_r.sel_wait == SYNC_FILL) begin
        st_nxt.sel_loaded = 1'b1;
        st_nxt.sa = DEFAULT_SA + {5'h00, st_r.sel3_s[1], st_r.sel2_s[1],
                                  st_r.sel1_s[1]};
      end else begin
        st_nxt.sel_wait = st_r.sel_wait + 2'h1;
      end
    end

    // address claim
    unique case (st_r.cst)
      CL_START: if (st_r.sel_loaded && !st_r.tx_v) begin
        st_nxt.tx = '{id: make_id(MGMT_PRIO, PGN_CLAIM, GLOBAL_DA,
                                  st_r.sa),
                      dlc: 4'h8, data: {8'h00, name}};
        st_nxt.tx_v = 1'b1;
        st_nxt.claim_cnt = '0;
        st_nxt.cst = CL_WAIT;
      end
      CL_WAIT: begin
        st_nxt.claim_cnt = st_r.claim_cnt + 32'h1;
        if (st_r.claim_cnt >= CLAIM_CYC - 1)
          st_nxt.cst = CL_DONE;
      end
      CL_DONE: ;
      CL_FAIL: ;
    endcase

    // timeout counted first so a taken frame restarts it
    if (st_r.to_cnt >= TIMEOUT_CYC - 1)
      st_nxt.tout = 1'b1;
    else
      st_nxt.to_cnt = st_r.to_cnt + 32'h1;

    if (link.h2d_valid) begin
      // contention: lower NAME value wins
      if (pgn == PGN_CLAIM && rsa == st_r.sa &&
          st_r.cst != CL_FAIL) begin
        if (link.h2d_frame.data[63:0] < name) begin
          if (st_r.sa >= MAX_SA) begin
            st_nxt.cst = CL_FAIL;
            st_nxt.sa  = NULL_SA;
          end else begin
            st_nxt.sa  = st_r.sa + 8'h01;
            st_nxt.cst = CL_START;
          end
        end else begin
          st_nxt.cst = CL_START;
        end
      end
      // commanded address addressed to our NAME
      if (pgn == PGN_CMD_ADDR &&
          link.h2d_frame.data[63:0] == name) begin
        st_nxt.sa  = frame_byte(link.h2d_frame.data, CMD_SA_BYTE);
        st_nxt.cst = CL_START;
      end
      // control frame; manual use drops it
      if (pgn == PGN_PROP_A && da == st_r.sa && st_r.cst == CL_DONE
          && !manual) begin
        st_nxt.pos = {frame_byte(link.h2d_frame.data, POS_HI_BYTE),
                      frame_byte(link.h2d_frame.data, POS_LO_BYTE)};
        st_nxt.cur = {frame_byte(link.h2d_frame.data, CUR_HI_BYTE),
                      frame_byte(link.h2d_frame.data, CUR_LO_BYTE)};
        st_nxt.spd = frame_byte(link.h2d_frame.data, SPD_BYTE);
        st_nxt.ctl = CTL_BITS'(frame_byte(link.h2d_frame.data,
                                          CTL_BYTE));
        en_new     = 1'b1;
        st_nxt.to_cnt = '0;
        st_nxt.tout   = 1'b0;
      end
    end

    // enable low clears overload and stops; rise starts motion
    if (!st_nxt.ctl[ENABLE_BIT]) begin
      st_nxt.run = 1'b0;
      st_nxt.ovl = 1'b0;
    end else if (en_new && !st_r.ctl[ENABLE_BIT] && !st_r.ovl) begin
      st_nxt.run = 1'b1;
    end

    // overload trip, start phase exempt
    if (st_r.run && !motor_starting_i && motor_current_i > st_r.cur)
    begin
      st_nxt.ovl_cnt = st_r.ovl_cnt + 32'h1;
      if (st_r.ovl_cnt >= OVERLOAD_CYC) begin
        st_nxt.ovl = 1'b1;
        st_nxt.run = 1'b0;
      end
    end else begin
      st_nxt.ovl_cnt = '0;
    end

    st_nxt.ext   = st_r.ext_s[1] |
                   (!manual && st_r.run && fb_position_i < st_r.pos);
    st_nxt.ret   = !st_r.ext_s[1] & (st_r.ret_s[1] |
                   (!manual && st_r.run && fb_position_i > st_r.pos));
    st_nxt.brake = st_r.ovl;
    st_nxt.claimed = (st_nxt.cst == CL_DONE);

    // periodic feedback on proprietary A2, even under manual control
    if (st_r.fb_cnt >= FEEDBACK_CYC - 1) begin
      st_nxt.fb_cnt = '0;
      if (st_r.cst == CL_DONE && !st_nxt.tx_v) begin
        st_nxt.tx = '{id: make_id(CTRL_PRIO, PGN_PROP_A2, GLOBAL_DA,
                                  st_r.sa) | 29'h01000000,
                      dlc: 4'h8,
                      data: {8'h00, fb_error_i | {2'h0, st_r.tout,
                             3'h0, st_r.ovl, 1'h0}, fb_motion_i, 8'h00,
                             fb_speed_i, fb_current_i, fb_position_i}};
        st_nxt.tx_v = 1'b1;
      end
    end else begin
      st_nxt.fb_cnt = st_r.fb_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      st_r <= RESET_ST;
    else
      st_r <= st_nxt;
  end

  assign link.d2h_frame    = st_r.tx;
  assign link.d2h_valid    = st_r.tx_v;
  assign target_position_o = st_r.pos;
  assign current_limit_o   = st_r.cur;
  assign target_speed_o    = st_r.spd;
  assign control_bits_o    = st_r.ctl;
  assign motion_run_o      = st_r.run;
  assign drive_extend_o    = st_r.ext;
  assign drive_retract_o   = st_r.ret;
  assign overload_o        = st_r.ovl;
  assign msg_timeout_o     = st_r.tout;
  assign brake_o           = st_r.brake;
  assign source_addr_o     = st_r.sa;
  assign addr_claimed_o    = st_r.claimed;
endmodule

// ### core/act_cmd_host.sv
/*
  Host end of the command port: sends the control frame every period
  or at once on request, to the actuator address the user gives, and
  hands received feedback frames to the user. Drives the bit tick.
*/
`timescale 1ns/1ns
module act_cmd_host
  import act_cmd_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = CTRL_PERIOD_MS * CLK_KHZ,
  parameter logic [7:0]  HOST_SA    = 8'h80
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // link
  act_cmd_if.host          link,
  // user command
  input  wire logic [7:0]  dest_addr_i,
  input  wire logic [15:0] target_position_i,
  input  wire logic [15:0] current_limit_i,
  input  wire logic [7:0]  target_speed_i,
  input  wire logic [5:0]  control_bits_i,
  input  wire logic        send_now_i,
  input  wire logic        periodic_en_i,
  // user feedback
  output logic [63:0]      feedback_data_o,
  output logic [7:0]       feedback_src_o,
  output logic             feedback_valid_o
);
  import act_cmd_pkg::*;

  typedef struct packed {
    logic [31:0] per_cnt;
    logic [15:0] bit_cnt;
    logic        tick;
    can_frame_t  tx;
    logic        tx_v;
    logic [63:0] fb;
    logic [7:0]  fb_src;
    logic        fb_v;
  } host_st_t;

  host_st_t st_r, st_nxt;
  logic     send;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tx_v = 1'b0;
    st_nxt.fb_v = 1'b0;
    // 250 kbit/s bit enable
    st_nxt.tick = (st_r.bit_cnt == 16'(BIT_CYCLES - 1));
    st_nxt.bit_cnt = st_nxt.tick ? 16'h0000 : st_r.bit_cnt + 16'h1;
    send = send_now_i;
    if (st_r.per_cnt >= PERIOD_CYC - 1) begin
      st_nxt.per_cnt = '0;
      send = send | periodic_en_i;
    end else begin
      st_nxt.per_cnt = st_r.per_cnt + 32'h1;
    end
    if (send) begin
      st_nxt.tx = '{id: make_id(CTRL_PRIO, PGN_PROP_A, dest_addr_i,
                                HOST_SA),
                    dlc: 4'h8,
                    data: {8'h00, 2'h0, control_bits_i, 16'h0000,
                           target_speed_i, current_limit_i[15:8],
                           current_limit_i[7:0], target_position_i[15:8],
                           target_position_i[7:0]}};
      st_nxt.tx_v = 1'b1;
    end
    if (link.d2h_valid &&
        {link.d2h_frame.id[25:16], 8'h00} == PGN_PROP_A2) begin
      st_nxt.fb     = link.d2h_frame.data[63:0];
      st_nxt.fb_src = link.d2h_frame.id[7:0];
      st_nxt.fb_v   = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign link.h2d_frame   = st_r.tx;
  assign link.h2d_valid   = st_r.tx_v;
  assign link.bit_tick    = st_r.tick;
  assign feedback_data_o  = st_r.fb;
  assign feedback_src_o   = st_r.fb_src;
  assign feedback_valid_o = st_r.fb_v;
endmodule

// ### dv/act_cmd_assertions.sv
/*
  Link checker for the actuator command port: frame kinds, spacing.
  Assumes both link ends on clk_i with an async active-low reset.
*/
`timescale 1ns/1ns
module act_cmd_assertions #(
  parameter int unsigned FEEDBACK_CYC = 50
) (
  // clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_b_i,
  // link
  input wire act_cmd_pkg::can_frame_t h2d_frame,
  input wire logic                    h2d_valid,
  input wire act_cmd_pkg::can_frame_t d2h_frame,
  input wire logic                    d2h_valid,
  input wire logic                    bit_tick
);
  import act_cmd_pkg::*;
  localparam logic [63:0] NAME_EXP = {NAME_AAC, NAME_IND_GRP, NAME_VS_INST,
    NAME_VS, 1'h0, NAME_FUNC, NAME_ECU_INST, NAME_FN_INST, NAME_MAKER,
    NAME_IDENT};
  typedef struct packed {
    logic [15:0] tick_cnt;
    logic        tick_seen;
    logic [31:0] fb_cnt;
    logic        fb_seen;
  } watch_t;
  watch_t watch_r;
  watch_t watch_nxt;
  logic   fb_frame;
  logic   claim_frame;
  assign fb_frame = d2h_valid && d2h_frame.id[25:16] == PGN_PROP_A2[17:8];
  assign claim_frame = d2h_valid && d2h_frame.id[25:16] == PGN_CLAIM[17:8];
  // cycles since last tick and last feedback frame
  always_comb begin
    watch_nxt = watch_r;
    watch_nxt.tick_cnt = bit_tick ? 16'h0 : watch_r.tick_cnt + 16'h1;
    watch_nxt.tick_seen = watch_r.tick_seen | bit_tick;
    watch_nxt.fb_cnt = fb_frame ? 32'h0 : watch_r.fb_cnt + 32'h1;
    watch_nxt.fb_seen = watch_r.fb_seen | fb_frame;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      watch_r <= '0;
    end else begin
      watch_r <= watch_nxt;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  tick_spacing_a: assert property (
    bit_tick && watch_r.tick_seen |-> watch_r.tick_cnt == BIT_CYCLES - 1)
    else $error("bit tick spacing wrong");
  ctrl_frame_a: assert property (
    h2d_valid |-> h2d_frame.id[28:26] == CTRL_PRIO &&
    h2d_frame.id[25:16] == PGN_PROP_A[17:8])
    else $error("control frame identifier wrong");
  ctrl_length_a: assert property (
    h2d_valid |-> h2d_frame.dlc == 4'h8)
    else $error("control frame length wrong");
  resp_group_a: assert property (
    d2h_valid |-> fb_frame || claim_frame)
    else $error("device sent unknown group");
  claim_name_a: assert property (
    claim_frame |-> d2h_frame.data[63:0] == NAME_EXP &&
    d2h_frame.id[15:8] == GLOBAL_DA)
    else $error("claim frame name wrong");
  fb_global_a: assert property (
    fb_frame |-> d2h_frame.id[15:8] == GLOBAL_DA && d2h_frame.dlc == 4'h8)
    else $error("feedback frame header wrong");
  claim_start_a: assert property (
    $rose(rst_b_i) |-> ##[1:4] claim_frame)
    else $error("no claim after reset");
  fb_period_a: assert property (
    fb_frame && watch_r.fb_seen |-> watch_r.fb_cnt == FEEDBACK_CYC - 1)
    else $error("feedback period wrong");
endmodule

// ### dv/j1939_actuator_command_port_test.sv
/*
  Testbench: host and actuator ends joined by one link, plus a second
  actuator fed by raw frames for claims and commanded address.
  Assumes the design package and interface compile first.
*/
`timescale 1ns/1ns
module j1939_actuator_command_port_test;
  import act_cmd_pkg::*;
  localparam int unsigned OVL = 20;
  localparam int unsigned TMO = 200;
  localparam int unsigned FB  = 50;
  localparam int unsigned PER = 60;
  localparam logic [7:0]  SA_A = DEFAULT_SA + 8'h05;
  localparam logic [63:0] NAME_EXP = {NAME_AAC, NAME_IND_GRP, NAME_VS_INST,
    NAME_VS, 1'h0, NAME_FUNC, NAME_ECU_INST, NAME_FN_INST, NAME_MAKER,
    NAME_IDENT};
  logic        clk_i;
  logic        rst_b_i;
  logic [2:0]  sel_a;
  logic [2:0]  sel_b;
  logic        manual_ext;
  logic        manual_ret;
  logic        starting;
  logic [15:0] motor_cur;
  logic [15:0] fb_pos;
  logic [15:0] fb_cur;
  logic [7:0]  fb_spd;
  logic [7:0]  fb_flags;
  logic [15:0] tgt_pos;
  logic [15:0] cur_lim;
  logic [7:0]  tgt_spd;
  logic [5:0]  ctl_bits;
  logic        run;
  logic        ext;
  logic        ret;
  logic        ovl;
  logic        tmo;
  logic        brake;
  logic [7:0]  sa;
  logic        claimed;
  logic [7:0]  sa_b;
  logic        claimed_b;
  logic [7:0]  dest;
  logic [15:0] h_pos;
  logic [15:0] h_cur;
  logic [7:0]  h_spd;
  logic [5:0]  h_ctl;
  logic        send_now;
  logic        periodic;
  logic [63:0] fb_data;
  logic [7:0]  fb_src;
  logic        fb_valid;
  int          fails;
  int          checks_done;
  int          cycles;
  act_cmd_if link();
  act_cmd_if link_b();
  assign link_b.bit_tick = link.bit_tick;
  act_cmd_device #(.OVERLOAD_CYC(OVL), .TIMEOUT_CYC(TMO), .FEEDBACK_CYC(FB),
                   .CLAIM_CYC(10)) i_act_cmd_device (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link(link),
    .addr_select_bit_one_i(sel_a[0]), .addr_select_bit_two_i(sel_a[1]),
    .addr_select_bit_three_i(sel_a[2]), .manual_extend_i(manual_ext),
    .manual_retract_i(manual_ret), .motor_starting_i(starting),
    .motor_current_i(motor_cur), .fb_position_i(fb_pos),
    .fb_current_i(fb_cur), .fb_speed_i(fb_spd), .fb_motion_i(fb_flags),
    .fb_error_i(fb_flags), .target_position_o(tgt_pos),
    .current_limit_o(cur_lim), .target_speed_o(tgt_spd),
    .control_bits_o(ctl_bits), .motion_run_o(run), .drive_extend_o(ext),
    .drive_retract_o(ret), .overload_o(ovl), .msg_timeout_o(tmo),
    .brake_o(brake), .source_addr_o(sa), .addr_claimed_o(claimed));
  act_cmd_device #(.OVERLOAD_CYC(OVL), .TIMEOUT_CYC(TMO), .FEEDBACK_CYC(FB),
                   .CLAIM_CYC(10)) i_act_cmd_device_b (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link(link_b),
    .addr_select_bit_one_i(sel_b[0]), .addr_select_bit_two_i(sel_b[1]),
    .addr_select_bit_three_i(sel_b[2]), .manual_extend_i(manual_ext),
    .manual_retract_i(manual_ret), .motor_starting_i(starting),
    .motor_current_i(motor_cur), .fb_position_i(fb_pos),
    .fb_current_i(fb_cur), .fb_speed_i(fb_spd), .fb_motion_i(8'h00),
    .fb_error_i(8'h00), .target_position_o(), .current_limit_o(),
    .target_speed_o(), .control_bits_o(), .motion_run_o(),
    .drive_extend_o(), .drive_retract_o(), .overload_o(),
    .msg_timeout_o(), .brake_o(), .source_addr_o(sa_b),
    .addr_claimed_o(claimed_b));
  act_cmd_host #(.PERIOD_CYC(PER)) i_act_cmd_host (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link(link), .dest_addr_i(dest),
    .target_position_i(h_pos), .current_limit_i(h_cur),
    .target_speed_i(h_spd), .control_bits_i(h_ctl), .send_now_i(send_now),
    .periodic_en_i(periodic), .feedback_data_o(fb_data),
    .feedback_src_o(fb_src), .feedback_valid_o(fb_valid));
  act_cmd_assertions #(.FEEDBACK_CYC(FB)) i_act_cmd_assertions (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .h2d_frame(link.h2d_frame),
    .h2d_valid(link.h2d_valid), .d2h_frame(link.d2h_frame),
    .d2h_valid(link.d2h_valid), .bit_tick(link.bit_tick));
  task automatic check(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic wait_high(ref logic s, input int lim);
    int k;
    k = 0;
    while (k < lim && s !== 1'b1) begin
      @(negedge clk_i);
      k++;
    end
    check(s, 1'b1, "awaited signal");
  endtask
  task automatic send(input logic [7:0] da, input logic [15:0] pos,
                      input logic [5:0] ctl);
    dest = da;
    h_pos = pos;
    h_ctl = ctl;
    send_now = 1'b1;
    @(negedge clk_i);
    send_now = 1'b0;
    wait_high(link.h2d_valid, 40);
    repeat (3) @(negedge clk_i);
  endtask
  // raw frame on the second link; whole frame inverted once released
  task automatic raw(input logic [28:0] id, input logic [71:0] data);
    link_b.h2d_frame = '{id: id, dlc: 4'h8, data: data};
    link_b.h2d_valid = 1'b1;
    @(negedge clk_i);
    link_b.h2d_valid = 1'b0;
    link_b.h2d_frame = ~link_b.h2d_frame;
  endtask
  task automatic claim_b(input logic [7:0] exp);
    int k;
    k = 0;
    while (k < 20 && !(link_b.d2h_valid === 1'b1 &&
           link_b.d2h_frame.id[25:16] === PGN_CLAIM[17:8])) begin
      @(negedge clk_i);
      k++;
    end
    check(link_b.d2h_frame.id[7:0], exp, "claim address");
    check(sa_b, exp, "source address");
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("wrong value at %0t: run too long", $time);
      finish_test();
    end
  end
  initial begin
    {rst_b_i, manual_ext, manual_ret, starting, send_now, periodic} = '0;
    {motor_cur, dest, h_pos, h_cur, h_ctl, sel_b} = '0;
    {fb_pos, fb_cur, fb_spd, h_spd, sel_a} = {16'h0123, 16'h0045, 8'h67,
                                              8'h2a, 3'h5};
    fb_flags = 8'h84;
    link_b.h2d_valid = 1'b0;
    link_b.h2d_frame = '0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    wait_high(claimed, 60);
    check(sa, SA_A, "strapped address");
    check(sa_b, DEFAULT_SA, "default address");
    raw({MGMT_PRIO, PGN_CLAIM[17:8], GLOBAL_DA, DEFAULT_SA}, 72'h0);
    claim_b(DEFAULT_SA + 8'h01);
    raw({MGMT_PRIO, PGN_CLAIM[17:8], GLOBAL_DA, sa_b}, {72{1'b1}});
    claim_b(DEFAULT_SA + 8'h01);
    raw({MGMT_PRIO, PGN_CMD_ADDR, 8'h80}, {8'h40, NAME_EXP});
    claim_b(8'h40);
    $display("test addressing done");
    h_cur = 16'h0050;
    send(SA_A, 16'h1234, 6'h00);
    check({tgt_pos, cur_lim, tgt_spd}, 40'h1234_0050_2a, "fields");
    check(run, 1'b0, "run while disabled");
    send(SA_A, 16'h1234, 6'h21);
    check(ctl_bits, 6'h21, "control bits");
    check(run, 1'b1, "run on enable");
    $display("test control done");
    motor_cur = 16'h0060;
    starting = 1'b1;
    repeat (OVL + 10) @(negedge clk_i);
    check(ovl, 1'b0, "trip in start phase");
    starting = 1'b0;
    repeat (OVL - 2) @(negedge clk_i);
    check(ovl, 1'b0, "early trip");
    wait_high(ovl, 10);
    check(run, 1'b0, "run after trip");
    @(negedge clk_i);
    check(brake, 1'b1, "brake");
    motor_cur = 16'h0000;
    send(SA_A, 16'h1234, 6'h00);
    check(ovl, 1'b0, "trip cleared");
    send(DEFAULT_SA, 16'h7777, 6'h00);
    check(tgt_pos, 16'h1234, "foreign frame");
    $display("test protection done");
    manual_ext = 1'b1;
    wait_high(ext, 8);
    send(SA_A, 16'h0999, 6'h00);
    check(tgt_pos, 16'h1234, "frame under manual");
    wait_high(fb_valid, FB + 10);
    check(fb_src, SA_A, "feedback source");
    check(fb_data[39:0], {fb_spd, fb_cur, fb_pos}, "feedback");
    check(fb_data[63:40], {fb_flags, fb_flags, 8'h00}, "flags");
    manual_ext = 1'b0;
    manual_ret = 1'b1;
    wait_high(ret, 8);
    manual_ret = 1'b0;
    repeat (4) @(negedge clk_i);
    send(SA_A, 16'h0321, 6'h00);
    check(tgt_pos, 16'h0321, "resumed");
    $display("test manual done");
    check(tmo, 1'b0, "timeout after frame");
    repeat (TMO - 20) @(negedge clk_i);
    check(tmo, 1'b0, "early timeout");
    wait_high(tmo, 40);
    send(SA_A, 16'h0321, 6'h00);
    check(tmo, 1'b0, "timeout cleared");
    h_pos = 16'h0abc;
    periodic = 1'b1;
    repeat (PER + 20) @(negedge clk_i);
    check(tgt_pos, 16'h0abc, "periodic frame");
    $display("test timing done");
    finish_test();
  end
endmodule

// ### inc/act_cmd_if.sv
/*
  Frame-level link between the actuator command port and its host.
  Each side offers a frame with a one-cycle valid; the carrier is the
  CAN network abstracted to whole frames, both ends on one clock.
*/
`timescale 1ns/1ns
interface act_cmd_if;
  import act_cmd_pkg::*;
  can_frame_t h2d_frame;
  logic       h2d_valid;
  can_frame_t d2h_frame;
  logic       d2h_valid;
  logic       bit_tick;

  modport device (input h2d_frame, input h2d_valid, input bit_tick,
                  output d2h_frame, output d2h_valid);
  modport host   (output h2d_frame, output h2d_valid, output bit_tick,
                  input d2h_frame, input d2h_valid);
endinterface

// ### inc/act_cmd_pkg.sv
/*
  Shared constants and types for the actuator command port: addressing,
  group numbers, NAME defaults, control-frame layout and timing counts.
  Assumes a 100 MHz clock and a CAN controller outside that hands over
  whole received frames and sends whole frames on request.
*/
package act_cmd_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CLK_KHZ       = CLK_HZ / 1000;
  localparam int unsigned BIT_RATE_BPS  = 250_000;
  localparam int unsigned BIT_CYCLES    = CLK_HZ / BIT_RATE_BPS;

  localparam logic [7:0]  DEFAULT_SA    = 8'h13;
  localparam logic [7:0]  MAX_SA        = 8'hfd;
  localparam logic [7:0]  GLOBAL_DA     = 8'hff;
  localparam logic [7:0]  NULL_SA       = 8'hfe;
  localparam logic [2:0]  CTRL_PRIO     = 3'h6;
  localparam logic [2:0]  MGMT_PRIO     = 3'h6;

  localparam logic [17:0] PGN_PROP_A    = 18'h0ef00;
  localparam logic [17:0] PGN_PROP_A2   = 18'h1ef00;
  localparam logic [17:0] PGN_CLAIM     = 18'h0ee00;
  localparam logic [17:0] PGN_CMD_ADDR  = 18'h0fed8;
  localparam logic [28:0] CTRL_ID_DFLT  = 29'h18ef1300;

  localparam logic       NAME_AAC       = 1'h1;
  localparam logic [2:0] NAME_IND_GRP   = 3'h0;
  localparam logic [3:0] NAME_VS_INST   = 4'h0;
  localparam logic [6:0] NAME_VS        = 7'h00;
  localparam logic [7:0] NAME_FUNC      = 8'hff;
  localparam logic [4:0] NAME_ECU_INST  = 5'h00;
  localparam logic [2:0] NAME_FN_INST   = 3'h0;
  localparam logic [20:0] NAME_IDENT    = 21'h000001;
  // arbitrary neutral maker code
  localparam logic [10:0] NAME_MAKER    = 11'h5a5;

  // control frame byte positions
  localparam int unsigned POS_LO_BYTE   = 0;
  localparam int unsigned POS_HI_BYTE   = 1;
  localparam int unsigned CUR_LO_BYTE   = 2;
  localparam int unsigned CUR_HI_BYTE   = 3;
  localparam int unsigned SPD_BYTE      = 4;
  localparam int unsigned CTL_BYTE      = 7;
  localparam int unsigned CTL_BITS      = 6;
  localparam int unsigned ENABLE_BIT    = 0;
  // commanded-address frame: NAME in 0..7, new address in byte 8
  localparam int unsigned CMD_SA_BYTE   = 8;

  localparam int unsigned OVERLOAD_MS   = 15;
  localparam int unsigned TIMEOUT_MS    = 5000;
  localparam int unsigned CTRL_PERIOD_MS = 100;
  localparam int unsigned FEEDBACK_MS   = 100;
  localparam int unsigned CLAIM_WAIT_MS = 250;

  typedef struct packed {
    logic [28:0] id;
    logic [3:0]  dlc;
    logic [71:0] data;
  } can_frame_t;

  function automatic logic [63:0] build_name();
    return {NAME_AAC, NAME_IND_GRP, NAME_VS_INST, NAME_VS, 1'h0,
            NAME_FUNC, NAME_ECU_INST, NAME_FN_INST, NAME_MAKER,
            NAME_IDENT};
  endfunction

  function automatic logic [28:0] make_id(input logic [2:0] prio,
                                          input logic [17:0] pgn,
                                          input logic [7:0] da,
                                          input logic [7:0] sa);
    return {prio, pgn[17:8], da, sa};
  endfunction

  function automatic logic [7:0] frame_byte(input logic [71:0] d,
                                            input int unsigned n);
    return d[8*n +: 8];
  endfunction
endpackage
